// >>> ffmt_pkg.sv
// Package for the freefall/motion event detector.
// Assumes one 100 MHz clock and a simple register port from an
// external serial-bus front end.
package ffmt_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h15;
  localparam logic [7:0] ADDR_SOURCE = 8'h16;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h17;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h18;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [7:0] DEBOUNCE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // Field positions
  localparam int SRC_ACTIVE_BIT = 7;
  localparam int THS_MODE_BIT = 7;
  localparam int CFG_LATCH_BIT = 7;
  localparam int CFG_COMBINE_BIT = 6;
  localparam int CFG_Z_EN_BIT = 5;
  localparam int CFG_Y_EN_BIT = 4;
  localparam int CFG_X_EN_BIT = 3;
  // Magnitude width: 8 g span at 0.063 g per count, 7-bit compare
  localparam int MAG_W = 7;

  // One sample of three axes, magnitude plus sign
  typedef struct packed {
    logic [MAG_W-1:0] z_mag;
    logic z_neg;
    logic [MAG_W-1:0] y_mag;
    logic y_neg;
    logic [MAG_W-1:0] x_mag;
    logic x_neg;
  } sample_t;

  // Register access from the serial-bus front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// >>> freefall_motion_detector.sv
// Freefall/motion detector with debounce and source register.
// Assumes samples arrive as one-cycle strobes at the output data
// rate, already scaled to 8 g span, and a register port per cycle.
module freefall_motion_detector
  import ffmt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic sample_valid_i,
  input wire sample_t sample_i,
  input wire reg_req_t reg_req_i,
  input wire logic detector_interrupt_enable_i,
  input wire logic detector_interrupt_route_i,
  output logic [7:0] reg_rdata_o,
  output logic int_line1_o,
  output logic int_line2_o
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] detector_config_register;
  logic [7:0] threshold_register;
  logic [7:0] debounce_count_register;
  logic [7:0] dbc;
  logic event_active_flag;
  logic [5:0] axis_flags;
  logic [6:0] threshold_value;
  logic debounce_mode_select, event_latch_enable, combination_select;
  logic x_detect_enable, y_detect_enable, z_detect_enable;
  logic src_read;
  logic count_wr;
  logic x_hi, y_hi, z_hi, cond;
  logic [5:0] live_flags, shown;
  logic [7:0] source_value;

  assign threshold_value = threshold_register[6:0];
  assign debounce_mode_select = threshold_register[THS_MODE_BIT];
  assign event_latch_enable = detector_config_register[CFG_LATCH_BIT];
  assign combination_select = detector_config_register[CFG_COMBINE_BIT];
  assign z_detect_enable = detector_config_register[CFG_Z_EN_BIT];
  assign y_detect_enable = detector_config_register[CFG_Y_EN_BIT];
  assign x_detect_enable = detector_config_register[CFG_X_EN_BIT];
  assign src_read = reg_req_i.rd && (reg_req_i.addr == ADDR_SOURCE);
  // Lowering the count pulls the counter down with it
  assign count_wr = reg_req_i.wr && (reg_req_i.addr == ADDR_DEBOUNCE);

  // ----------------------------------------------------------------
  // Axis comparison and combination
  // ----------------------------------------------------------------
  // Counts of 0.063 g over 8 g span, independent of full scale
  assign x_hi = sample_i.x_mag > threshold_value;
  assign y_hi = sample_i.y_mag > threshold_value;
  assign z_hi = sample_i.z_mag > threshold_value;
  // Disabled axes drop out of both combinations
  always_comb begin
    if (combination_select) begin
      cond = (x_detect_enable && x_hi) || (y_detect_enable && y_hi) ||
             (z_detect_enable && z_hi);
    end else begin
      cond = (x_detect_enable || y_detect_enable || z_detect_enable) &&
             (!x_detect_enable || !x_hi) && (!y_detect_enable || !y_hi) &&
             (!z_detect_enable || !z_hi);
    end
  end

  // Live per-axis flags, polarity one for negative g
  assign live_flags = {z_detect_enable && z_hi,
                       z_detect_enable && z_hi && sample_i.z_neg,
                       y_detect_enable && y_hi,
                       y_detect_enable && y_hi && sample_i.y_neg,
                       x_detect_enable && x_hi,
                       x_detect_enable && x_hi && sample_i.x_neg};

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      detector_config_register <= CONFIG_RESET;
      threshold_register <= THRESHOLD_RESET;
      debounce_count_register <= DEBOUNCE_RESET;
    end else if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        ADDR_CONFIG: detector_config_register <= {reg_req_i.wdata[7:3],
                                                  3'h0};
        ADDR_THRESHOLD: threshold_register <= reg_req_i.wdata;
        ADDR_DEBOUNCE: debounce_count_register <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Debounce counter, one step per sample
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dbc <= 8'h00;
    end else if (src_read && event_latch_enable) begin
      dbc <= 8'h00;
    end else if (count_wr && dbc >= reg_req_i.wdata) begin
      dbc <= reg_req_i.wdata;
    end else if (sample_valid_i) begin
      if (cond) begin
        if (dbc < debounce_count_register) begin
          dbc <= dbc + 8'h01;
        end else begin
          dbc <= debounce_count_register;
        end
      end else if (debounce_mode_select) begin
        dbc <= 8'h00;
      end else if (dbc != 8'h00) begin
        dbc <= dbc - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event-active flag
  // ----------------------------------------------------------------
  // Next counter value decides the flag in the same sample
  logic [7:0] next_dbc;
  always_comb begin
    next_dbc = dbc;
    if (cond) begin
      next_dbc = (dbc < debounce_count_register) ? dbc + 8'h01
                                                 : debounce_count_register;
    end else if (debounce_mode_select) begin
      next_dbc = 8'h00;
    end else if (dbc != 8'h00) begin
      next_dbc = dbc - 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      event_active_flag <= 1'b0;
    end else if (event_latch_enable) begin
      // Set beats a read in the same cycle
      if (sample_valid_i && cond &&
          next_dbc == debounce_count_register) begin
        event_active_flag <= 1'b1;
      end else if (src_read) begin
        event_active_flag <= 1'b0;
      end
    end else if (sample_valid_i) begin
      event_active_flag <= cond &&
                           (next_dbc == debounce_count_register);
    end
  end

  // ----------------------------------------------------------------
  // Axis flags: live, or frozen while latched event stands
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      axis_flags <= 6'h00;
    end else if (event_latch_enable && event_active_flag && !src_read) begin
      axis_flags <= axis_flags;
    end else if (event_latch_enable && src_read) begin
      axis_flags <= 6'h00;
    end else if (sample_valid_i) begin
      axis_flags <= live_flags;
    end
  end

  // Mask disabled axes on read
  assign shown = axis_flags & {{2{z_detect_enable}}, {2{y_detect_enable}},
                               {2{x_detect_enable}}};
  assign source_value = {event_active_flag, 1'b0, shown};

  // ----------------------------------------------------------------
  // Read data and interrupt outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        ADDR_CONFIG: reg_rdata_o <= detector_config_register;
        ADDR_SOURCE: reg_rdata_o <= source_value;
        ADDR_THRESHOLD: reg_rdata_o <= threshold_register;
        ADDR_DEBOUNCE: reg_rdata_o <= debounce_count_register;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Route one selects line 1, zero line 2
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_line1_o <= 1'b0;
      int_line2_o <= 1'b0;
    end else begin
      int_line1_o <= event_active_flag && detector_interrupt_enable_i &&
                     detector_interrupt_route_i;
      int_line2_o <= event_active_flag && detector_interrupt_enable_i &&
                     !detector_interrupt_route_i;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_saturate;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $stable(debounce_count_register) |-> dbc <= debounce_count_register;
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter over");

  property p_clear_mode;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      sample_valid_i && !cond && debounce_mode_select && !reg_req_i.wr
      |=> dbc == 8'h00;
  endproperty
  a_clear_mode: assert property (p_clear_mode) else $error("no clear");

  property p_decrement;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      sample_valid_i && !cond && !debounce_mode_select && dbc != 8'h00 &&
      !src_read && !count_wr |=> dbc == $past(dbc) - 8'h01;
  endproperty
  a_decrement: assert property (p_decrement) else $error("no decr");

  property p_increment;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      sample_valid_i && cond && dbc < debounce_count_register &&
      !src_read && !reg_req_i.wr |=> dbc == $past(dbc) + 8'h01;
  endproperty
  a_increment: assert property (p_increment) else $error("no incr");

  property p_hold;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !sample_valid_i && !src_read && !count_wr |=> $stable(dbc);
  endproperty
  a_hold: assert property (p_hold) else $error("step off sample");

  property p_latch_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      src_read && event_latch_enable && !reg_req_i.wr
      |=> dbc == 8'h00 && axis_flags == 6'h00;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("no clr");

  property p_latch_hold;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      event_latch_enable && event_active_flag && !src_read
      |=> $stable(axis_flags);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("unfrozen");

  property p_mask;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !x_detect_enable |-> source_value[1:0] == 2'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("x not masked");

  property p_irq;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      event_active_flag && detector_interrupt_enable_i &&
      detector_interrupt_route_i |=> int_line1_o;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");

  property p_zero_count;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      sample_valid_i && cond && debounce_count_register == 8'h00
      |=> event_active_flag;
  endproperty
  a_zero_count: assert property (p_zero_count)
    else $error("no set on zero count");

  property p_below_count;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      sample_valid_i && !event_latch_enable &&
      debounce_count_register > 8'h01 &&
      dbc < debounce_count_register - 8'h01 |=> !event_active_flag;
  endproperty
  a_below_count: assert property (p_below_count)
    else $error("early event");

  property p_polarity;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      sample_valid_i && !event_latch_enable && x_detect_enable &&
      sample_i.x_mag > threshold_value
      |=> axis_flags[1:0] == {1'b1, $past(sample_i.x_neg)};
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("x flags wrong");

  property p_motion;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      sample_valid_i && !event_latch_enable && combination_select &&
      debounce_count_register == 8'h00 && z_detect_enable &&
      sample_i.z_mag > threshold_value |=> event_active_flag;
  endproperty
  a_motion: assert property (p_motion)
    else $error("motion missed");

  property p_freefall;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      sample_valid_i && !event_latch_enable && !combination_select &&
      x_detect_enable && sample_i.x_mag > threshold_value
      |=> !event_active_flag;
  endproperty
  a_freefall: assert property (p_freefall)
    else $error("false freefall");

  property p_source_read;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      src_read |=> reg_rdata_o == $past(source_value) && !reg_rdata_o[6];
  endproperty
  a_source_read: assert property (p_source_read)
    else $error("source read");

  property p_irq_line2;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      event_active_flag && detector_interrupt_enable_i &&
      !detector_interrupt_route_i |=> int_line2_o && !int_line1_o;
  endproperty
  a_irq_line2: assert property (p_irq_line2)
    else $error("no line 2");

  property p_irq_off;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !detector_interrupt_enable_i |=> !int_line1_o && !int_line2_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("ungated interrupt");

  property p_mask_y;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !y_detect_enable |-> source_value[3:2] == 2'h0;
  endproperty
  a_mask_y: assert property (p_mask_y) else $error("y not masked");

  property p_mask_z;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !z_detect_enable |-> source_value[5:4] == 2'h0;
  endproperty
  a_mask_z: assert property (p_mask_z) else $error("z not masked");

  property p_latch_flag;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      event_latch_enable && event_active_flag && !src_read
      |=> event_active_flag;
  endproperty
  a_latch_flag: assert property (p_latch_flag)
    else $error("latched flag lost");

  c_event: cover property (@(posedge core_clk_i) $rose(event_active_flag));
  c_latched_read: cover property (@(posedge core_clk_i)
    event_active_flag && event_latch_enable && src_read);
  c_decrement: cover property (@(posedge core_clk_i)
    sample_valid_i && !cond && !debounce_mode_select && dbc != 8'h00);
  c_freefall: cover property (@(posedge core_clk_i)
    sample_valid_i && cond && !combination_select);
endmodule

// >>> host_model.sv
// Host-side register master for the detector bench.
// Assumes requests are taken on the rising clock edge.
module host_model
  import ffmt_pkg::*;
(
  input wire logic core_clk_i,
  output reg_req_t reg_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial reg_req_o = '0;
  // One-cycle write; released lines show inverted data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk_i);
    reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // One-cycle read request
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk_i);
    reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
    @(negedge core_clk_i);
    reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
  endtask
endmodule

// >>> tb.sv
// Self-checking bench for the freefall/motion detector.
// Assumes the host model drives the register port.
module tb;
  import ffmt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sample_valid_i = 1'b0;
  sample_t sample_i = '0;
  reg_req_t reg_req;
  logic int_en = 1'b0;
  logic int_route = 1'b1;
  logic [7:0] reg_rdata;
  logic int1;
  logic int2;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int cmp_count = 0;
  logic [6:0] th;
  logic [7:0] lp;
  logic [7:0] hp;
  logic [7:0] hn;
  always #5 core_clk_i = ~core_clk_i;
  host_model i_host_model (.core_clk_i(core_clk_i), .reg_req_o(reg_req));
  freefall_motion_detector i_freefall_motion_detector (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .sample_valid_i(sample_valid_i),
    .sample_i(sample_i),
    .reg_req_i(reg_req),
    .detector_interrupt_enable_i(int_en),
    .detector_interrupt_route_i(int_route),
    .reg_rdata_o(reg_rdata),
    .int_line1_o(int1),
    .int_line2_o(int2)
  );
  // ----------------------------------------------------------------
  // Comparison, verdict and read watcher
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk_i) rd_d <= reg_req.rd;
  // Read data is due the cycle after the read edge
  always @(negedge core_clk_i) begin
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host_model.rd(a);
  endtask
  task automatic smp(input sample_t s);
    @(negedge core_clk_i);
    sample_valid_i = 1'b1;
    sample_i = s;
    @(negedge core_clk_i);
    sample_valid_i = 1'b0;
    sample_i = ~s;
  endtask
  // Bit set sends x above threshold, clear sends all at threshold
  task automatic run(input logic [7:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      smp(pat[i] ? {lp, lp, hp} : {lp, lp, lp});
    end
  endtask
  task automatic chk_int(input logic [7:0] e);
    repeat (2) @(negedge core_clk_i);
    check("int_lines", {6'h00, int1, int2}, e);
  endtask
  initial begin
    #50us;
    miscompares++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h7a1d825f));
    th = 7'($urandom_range(1, 126));
    lp = {th, 1'b0};
    hp = {th + 7'h01, 1'b0};
    hn = {th + 7'h01, 1'b1};
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i) reset_n_i = 1'b1;
    rd_exp(ADDR_THRESHOLD, 8'h00);
    rd_exp(ADDR_DEBOUNCE, 8'h00);
    rd_exp(ADDR_SOURCE, 8'h00);
    rd_exp(8'h20, 8'h00);
    i_host_model.wr(ADDR_SOURCE, 8'hff);
    rd_exp(ADDR_SOURCE, 8'h00);
    i_host_model.wr(ADDR_THRESHOLD, {1'b0, th});
    rd_exp(ADDR_THRESHOLD, {1'b0, th});
    // Motion, all axes, no debounce
    i_host_model.wr(ADDR_CONFIG, 8'h78);
    smp({lp, lp, hn});
    rd_exp(ADDR_SOURCE, 8'h83);
    int_en = 1'b1;
    chk_int(8'h02);
    int_route = 1'b0;
    chk_int(8'h01);
    int_en = 1'b0;
    chk_int(8'h00);
    smp({hp, lp, lp});
    rd_exp(ADDR_SOURCE, 8'ha0);
    smp({lp, {th, 1'b1}, lp});
    rd_exp(ADDR_SOURCE, 8'h00);
    // Only x enabled
    i_host_model.wr(ADDR_CONFIG, 8'h48);
    smp({hn, hn, lp});
    rd_exp(ADDR_SOURCE, 8'h00);
    // Freefall on all axes
    i_host_model.wr(ADDR_CONFIG, 8'h38);
    smp({lp, lp, lp});
    rd_exp(ADDR_SOURCE, 8'h80);
    smp({lp, hn, lp});
    rd_exp(ADDR_SOURCE, 8'h0c);
    // Debounce of three, decrement mode
    i_host_model.wr(ADDR_CONFIG, 8'h78);
    i_host_model.wr(ADDR_DEBOUNCE, 8'h03);
    rd_exp(ADDR_DEBOUNCE, 8'h03);
    run(8'h0b, 4);
    rd_exp(ADDR_SOURCE, 8'h02);
    run(8'h01, 1);
    rd_exp(ADDR_SOURCE, 8'h82);
    run(8'h05, 3);
    rd_exp(ADDR_SOURCE, 8'h82);
    // Clear mode
    i_host_model.wr(ADDR_THRESHOLD, {1'b1, th});
    run(8'h36, 6);
    rd_exp(ADDR_SOURCE, 8'h02);
    run(8'h01, 1);
    rd_exp(ADDR_SOURCE, 8'h82);
    // Latched motion
    i_host_model.wr(ADDR_THRESHOLD, {1'b0, th});
    i_host_model.wr(ADDR_DEBOUNCE, 8'h00);
    i_host_model.wr(ADDR_CONFIG, 8'hf8);
    smp({lp, lp, hp});
    smp({lp, hn, lp});
    rd_exp(ADDR_SOURCE, 8'h82);
    rd_exp(ADDR_SOURCE, 8'h00);
    smp({lp, hn, lp});
    smp({hp, lp, lp});
    rd_exp(ADDR_SOURCE, 8'h8c);
    // Reset in mid-run brings registers and flags back to zero
    @(negedge core_clk_i) reset_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    rd_exp(ADDR_THRESHOLD, 8'h00);
    rd_exp(ADDR_SOURCE, 8'h00);
    repeat (3) @(negedge core_clk_i);
    summarize();
  end
endmodule
